// *** include/agu_pkg.sv ***
// Purpose: shared types and constants for the address generation unit
// Assumes: single clock, 32-bit linear space, 24-bit physical address pins
// Notes:   no registers reachable by software
`default_nettype none
package agu_pkg;
  localparam int ADDR_WIDTH     = 32;
  localparam int PHYS_WIDTH     = 24;
  localparam int PAGE_SHIFT     = 12;
  localparam int REAL_SHIFT     = 4;
  localparam int REAL_WIDTH     = 20;
  localparam int GPR_COUNT      = 8;
  localparam logic [2:0] SP_INDEX = 3'h4;
  localparam logic [2:0] BP_INDEX = 3'h5;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    AGU_SEG_EXTRA, AGU_SEG_CODE, AGU_SEG_STACK, AGU_SEG_DATA, AGU_SEG_XTRA2, AGU_SEG_XTRA3
  } agu_seg_type;

  typedef enum logic [1:0] {
    AGU_REF_CODE, AGU_REF_STACK, AGU_REF_STRING, AGU_REF_DATA
  } agu_ref_type;

  typedef enum logic [2:0] {
    AGU_MODE_REGISTER, AGU_MODE_IMMEDIATE, AGU_MODE_DIRECT, AGU_MODE_REG_INDIRECT,
    AGU_MODE_BASED, AGU_MODE_SCALED_INDEX, AGU_MODE_BASED_SCALED, AGU_MODE_BASED_SCALED_DISP
  } agu_mode_type;

  typedef enum logic [1:0] {AGU_DISP_NONE, AGU_DISP_8, AGU_DISP_16, AGU_DISP_32} agu_disp_type;
  typedef enum logic [1:0] {AGU_SIZE_BYTE, AGU_SIZE_WORD, AGU_SIZE_DWORD} agu_size_type;

  typedef struct packed {
    agu_mode_type mode;
    agu_ref_type  refKind;
    logic         overrideValid;
    agu_seg_type  overrideSeg;
    logic [2:0]   baseSel;
    logic [2:0]   indexSel;
    logic [1:0]   scaleLog2;
    agu_disp_type dispSize;
    logic [31:0]  displacement;
    logic [31:0]  instrPointer;
    logic         addrSizeToggle;
    agu_size_type opSize;
    logic [31:0]  storeData;
  } agu_req_type;

  typedef struct packed {
    logic [31:0] effectiveAddress;
    logic [15:0] selector;
    logic [31:0] linearAddress;
    logic        pageRequest;
    logic [23:0] physicalAddress;
    logic [19:0] pageNumber;
    logic [11:0] pageOffset;
    logic        addr32;
    logic [3:0]  byteEnable;
    logic [31:0] laneData;
  } agu_result_type;
endpackage : agu_pkg
`default_nettype wire

// *** hw/agu_segment_select.sv ***
// Purpose: pick the segment register for a reference
// Assumes: override eligibility decided here; code, stack push/pop, string dest fixed
// Notes:   purely combinational
`default_nettype none
`timescale 1ns/1ps
module agu_segment_select (
  input  wire agu_pkg::agu_ref_type refKind,
  input  wire logic                 overrideValid,
  input  wire agu_pkg::agu_seg_type overrideSeg,
  input  wire logic                 baseUsed,
  input  wire logic [2:0]           baseSel,
  output agu_pkg::agu_seg_type      segChoice
);
  always_comb begin
    case (refKind)
      agu_pkg::AGU_REF_CODE:   segChoice = agu_pkg::AGU_SEG_CODE;
      agu_pkg::AGU_REF_STACK:  segChoice = agu_pkg::AGU_SEG_STACK;
      agu_pkg::AGU_REF_STRING: segChoice = agu_pkg::AGU_SEG_EXTRA;
      agu_pkg::AGU_REF_DATA: begin
        if (overrideValid) begin
          segChoice = overrideSeg;
        end else if (baseUsed && (baseSel == agu_pkg::SP_INDEX || baseSel == agu_pkg::BP_INDEX)) begin
          segChoice = agu_pkg::AGU_SEG_STACK;
        end else begin
          segChoice = agu_pkg::AGU_SEG_DATA;
        end
      end
      default: segChoice = agu_pkg::AGU_SEG_DATA;
    endcase
  end
endmodule : agu_segment_select
`default_nettype wire

// *** hw/agu_lane_order.sv ***
// Purpose: little-endian byte enables and lane placement for an operand
// Assumes: 32-bit internal word; low address bits pick the starting lane
// Notes:   lanes beyond byte 3 wrap into the next word, handled by the bus side
`default_nettype none
`timescale 1ns/1ps
module agu_lane_order (
  input  wire agu_pkg::agu_size_type opSize,
  input  wire logic [1:0]            lowAddr,
  input  wire logic [31:0]           storeData,
  output logic [3:0]                 byteEnable,
  output logic [31:0]                laneData
);
  logic [3:0] sizeMask;
  always_comb begin
    case (opSize)
      agu_pkg::AGU_SIZE_BYTE:  sizeMask = 4'h1;
      agu_pkg::AGU_SIZE_WORD:  sizeMask = 4'h3;
      agu_pkg::AGU_SIZE_DWORD: sizeMask = 4'hf;
      default:                 sizeMask = 4'h1;
    endcase
    // least significant byte lands at the lowest address
    byteEnable = 4'((sizeMask << lowAddr) | (sizeMask >> (3'd4 - {1'b0, lowAddr})));
    laneData   = (storeData << {lowAddr, 3'b000}) | (storeData >> (6'd32 - {lowAddr, 3'b000}));
  end
endmodule : agu_lane_order
`default_nettype wire

// *** hw/address_generation_unit.sv ***
// Purpose: effective, linear and physical address generation
// Assumes: decoder holds a request steady until accepted; segment bases come from the core
// Notes:   descriptor lookup and page translation live outside this block
//
// Behaviour
// - multi-byte operands stored least significant byte first, ascending addresses
// - operand address is the address of its least significant byte
// - pages are fixed 4K byte blocks
// - logical address is segment selector plus effective address offset
// - linear address is 32 bits; without paging keep only low 24 bits
// - real mode: selector shifted left four plus offset, 1 megabyte space
// - real mode never uses page translation
// - protected mode with paging sends linear address to page translation
// - defaults: data to data segment, stack to stack, fetch to code with pointer
// - override prefix replaces default; only way to extra segments (honoured for data refs only; string refs use extra)
// - segment bases may overlap freely, all may be zero
// - segment sizes range from 1 byte to 4 gigabytes
// - eight modes: register, immediate and six memory modes
// - displacement is 8, 16 or 32 bit immediate
// - 32-bit base may be any general register
// - index is any register but stack pointer, scaled 1, 2, 4 or 8
// - address pipelined at no cost; base plus index costs one clock
// - address is base plus scaled index plus displacement, absent parts zero
// - direct mode offset is the displacement only
// - register indirect offset is base register only
// - based: base plus displacement; scaled index: scaled index plus displacement
// - based scaled index adds base and scaled index, optionally displacement
// - default-size flag 0 gives 16-bit, 1 gives 32-bit; real mode 16-bit
`default_nettype none
`timescale 1ns/1ps
module address_generation_unit (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      reqValid,
  input  wire agu_pkg::agu_req_type      req,
  input  wire logic [31:0]               gprFile [agu_pkg::GPR_COUNT],
  input  wire logic [15:0]               segSelector [6],
  input  wire logic [31:0]               segBase [6],
  input  wire logic                      protectEnable,
  input  wire logic                      pagingEnable,
  input  wire logic                      defaultSize32,
  output logic                           reqReady,
  output logic                           resultValid,
  output agu_pkg::agu_result_type        result
);
  // ==========================================================
  // operand decode
  logic        baseUsed, indexUsed, dispUsed, memMode, addr32;
  logic [31:0] baseVal, indexVal, scaledIndex, dispVal;
  agu_pkg::agu_seg_type segChoice;

  always_comb begin
    baseUsed  = 1'b0;
    indexUsed = 1'b0;
    dispUsed  = 1'b0;
    memMode   = 1'b1;
    case (req.mode)
      agu_pkg::AGU_MODE_REGISTER:          memMode = 1'b0;
      agu_pkg::AGU_MODE_IMMEDIATE:         memMode = 1'b0;
      agu_pkg::AGU_MODE_DIRECT:            dispUsed = 1'b1;
      agu_pkg::AGU_MODE_REG_INDIRECT:      baseUsed = 1'b1;
      agu_pkg::AGU_MODE_BASED: begin
        baseUsed = 1'b1;
        dispUsed = 1'b1;
      end
      agu_pkg::AGU_MODE_SCALED_INDEX: begin
        indexUsed = 1'b1;
        dispUsed  = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_SCALED: begin
        baseUsed  = 1'b1;
        indexUsed = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_SCALED_DISP: begin
        baseUsed  = 1'b1;
        indexUsed = 1'b1;
        dispUsed  = 1'b1;
      end
      default: memMode = 1'b0;
    endcase
    // address size: descriptor flag in protected mode, 16 in real mode, prefix flips it in either mode
    addr32 = (protectEnable & defaultSize32) ^ req.addrSizeToggle;
    // any register may be a base; stack pointer as index reads as absent
    baseVal  = baseUsed ? gprFile[req.baseSel] : agu_pkg::ADDR_RESET;
    indexVal = (indexUsed && req.indexSel != agu_pkg::SP_INDEX) ?
               gprFile[req.indexSel] : agu_pkg::ADDR_RESET;
    scaledIndex = indexVal << req.scaleLog2;
    case (req.dispSize)
      agu_pkg::AGU_DISP_8:  dispVal = {{24{req.displacement[7]}}, req.displacement[7:0]};
      agu_pkg::AGU_DISP_16: dispVal = {{16{req.displacement[15]}}, req.displacement[15:0]};
      agu_pkg::AGU_DISP_32: dispVal = req.displacement;
      default:              dispVal = agu_pkg::ADDR_RESET;
    endcase
    if (!dispUsed) begin
      dispVal = agu_pkg::ADDR_RESET;
    end
  end

  agu_segment_select u_segment_select (
    .refKind       (req.refKind),
    .overrideValid (req.overrideValid),
    .overrideSeg   (req.overrideSeg),
    .baseUsed      (baseUsed),
    .baseSel       (req.baseSel),
    .segChoice     (segChoice)
  );

  // ==========================================================
  // handshake: base plus index takes one extra clock
  typedef enum {AGU_IDLE, AGU_SECOND} agu_state_type;
  agu_state_type stateReg, stateNext;
  logic          acceptNow, needExtra, takeNow;
  logic          readyReg, readyNext;
  logic [31:0]   partialReg, partialNext;

  assign needExtra = baseUsed & indexUsed;
  // a request still held while its ready pulse stands is the same one: never take it twice
  assign takeNow   = reqValid & ~readyReg;

  always_comb begin
    stateNext   = stateReg;
    partialNext = partialReg;
    acceptNow   = 1'b0;
    case (stateReg)
      AGU_IDLE: begin
        if (takeNow && needExtra) begin
          stateNext   = AGU_SECOND;
          partialNext = baseVal + scaledIndex;
        end else if (takeNow) begin
          acceptNow = 1'b1;
        end
      end
      AGU_SECOND: begin
        stateNext = AGU_IDLE;
        acceptNow = 1'b1;
      end
      default: stateNext = AGU_IDLE;
    endcase
  end

  // ==========================================================
  // address arithmetic
  logic [31:0] eaFull, eaSized, segLinear, linear;
  logic [15:0] selVal;
  logic [3:0]  laneEnable;
  logic [31:0] laneData;

  always_comb begin
    if (req.refKind == agu_pkg::AGU_REF_CODE) begin
      eaFull = req.instrPointer;
    end else if (stateReg == AGU_SECOND) begin
      eaFull = partialReg + dispVal;
    end else begin
      eaFull = baseVal + scaledIndex + dispVal;
    end
    eaSized = addr32 ? eaFull : {16'h0000, eaFull[15:0]};
    selVal  = segSelector[segChoice];
    // bases may coincide or all be zero; no overlap check exists
    // no limit check: offset spans the full 4 gigabyte segment range
    segLinear = ({16'h0000, selVal} << agu_pkg::REAL_SHIFT) + eaSized;
    if (protectEnable) begin
      linear = segBase[segChoice] + eaSized;
    end else begin
      linear = {12'h000, segLinear[agu_pkg::REAL_WIDTH-1:0]};
    end
  end

  agu_lane_order u_lane_order (
    .opSize     (req.opSize),
    .lowAddr    (linear[1:0]),
    .storeData  (req.storeData),
    .byteEnable (laneEnable),
    .laneData   (laneData)
  );

  // ==========================================================
  // result register
  agu_pkg::agu_result_type resultReg, resultNext;
  logic                    validReg, validNext;

  always_comb begin
    resultNext = resultReg;
    validNext  = acceptNow & memMode;
    readyNext  = acceptNow;
    if (acceptNow) begin
      resultNext.effectiveAddress = eaSized;
      resultNext.selector         = selVal;
      resultNext.linearAddress    = linear;
      resultNext.pageRequest      = protectEnable & pagingEnable;
      resultNext.physicalAddress  = linear[agu_pkg::PHYS_WIDTH-1:0];
      resultNext.pageNumber       = linear[31:agu_pkg::PAGE_SHIFT];
      resultNext.pageOffset       = linear[agu_pkg::PAGE_SHIFT-1:0];
      resultNext.addr32           = addr32;
      resultNext.byteEnable       = laneEnable;
      resultNext.laneData         = laneData;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stateReg   <= AGU_IDLE;
      partialReg <= agu_pkg::ADDR_RESET;
      resultReg  <= '0;
      validReg   <= 1'b0;
      readyReg   <= 1'b0;
    end else begin
      stateReg   <= stateNext;
      partialReg <= partialNext;
      resultReg  <= resultNext;
      validReg   <= validNext;
      readyReg   <= readyNext;
    end
  end

  assign result      = resultReg;
  assign resultValid = validReg;
  assign reqReady    = readyReg;

  // ==========================================================
  // checks
  sequence s_dual_start;
    takeNow && stateReg == AGU_IDLE && baseUsed && indexUsed;
  endsequence

  a_dual_extra_clock: assert property (@(posedge clock) disable iff (!reset_n)
    s_dual_start |=> stateReg == AGU_SECOND ##1 reqReady)
    else $error("base plus index did not take exactly one extra clock");
  a_single_no_wait: assert property (@(posedge clock) disable iff (!reset_n)
    takeNow && stateReg == AGU_IDLE && !(baseUsed && indexUsed) |=> reqReady)
    else $error("single component address stalled");
  a_real_no_paging: assert property (@(posedge clock) disable iff (!reset_n)
    resultValid && !$past(protectEnable) |-> !result.pageRequest && result.linearAddress[31:20] == 12'h000)
    else $error("real mode address routed to paging or above 1 megabyte");
  a_phys_truncate: assert property (@(posedge clock) disable iff (!reset_n)
    resultValid |-> result.physicalAddress == result.linearAddress[23:0])
    else $error("physical address is not low 24 bits of linear");
  a_page_split: assert property (@(posedge clock) disable iff (!reset_n)
    resultValid |-> {result.pageNumber, result.pageOffset} == result.linearAddress)
    else $error("page split is not 4K");
  a_prot_linear: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && protectEnable |=> result.linearAddress == $past(segBase[segChoice] + eaSized))
    else $error("protected linear address wrong");
  a_direct_disp: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && req.mode == agu_pkg::AGU_MODE_DIRECT && addr32 && req.refKind != agu_pkg::AGU_REF_CODE
      |=> result.effectiveAddress == $past(dispVal))
    else $error("direct mode offset is not the displacement");
  a_index_no_sp: assert property (@(posedge clock) disable iff (!reset_n)
    indexUsed && req.indexSel == agu_pkg::SP_INDEX |-> scaledIndex == 32'h0000_0000)
    else $error("stack pointer used as index");
  a_word_lanes: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && req.opSize == agu_pkg::AGU_SIZE_WORD && linear[1:0] == 2'h0 |=> result.byteEnable == 4'h3)
    else $error("word not at two ascending lanes");
  a_ready_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    reqReady |=> !reqReady)
    else $error("ready held for more than one cycle");
  a_real_default16: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && !protectEnable && !req.addrSizeToggle |=> !result.addr32)
    else $error("real mode did not default to 16-bit addressing");
  a_code_offset: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && req.refKind == agu_pkg::AGU_REF_CODE && addr32
      |=> result.effectiveAddress == $past(req.instrPointer))
    else $error("code fetch offset is not the instruction pointer");
  a_nomem_novalid: assert property (@(posedge clock) disable iff (!reset_n)
    acceptNow && !memMode |=> !resultValid)
    else $error("register or immediate mode raised a memory result");
endmodule : address_generation_unit
`default_nettype wire

// *** tb/agu_core_model.sv ***
// Purpose: decoder and execution core model that feeds address requests
// Assumes: one request at a time, held steady until the ready pulse is seen
// Notes:   register file and segment tables are written by the bench between requests
`timescale 1ns/1ps
`default_nettype none
module agu_core_model (
  input  wire logic                    clock,
  output var logic                     reqValid,
  output var agu_pkg::agu_req_type     req,
  output var logic [31:0]              gprFile [agu_pkg::GPR_COUNT],
  output var logic [15:0]              segSelector [6],
  output var logic [31:0]              segBase [6],
  input  wire logic                    reqReady,
  input  wire logic                    resultValid,
  input  wire agu_pkg::agu_result_type result
);
  // ==========================================================================
  // power-up state
  initial begin
    reqValid = 1'b0;
    req      = '0;
    for (int i = 0; i < 8; i++) begin
      gprFile[i] = 32'h0;
    end
    for (int i = 0; i < 6; i++) begin
      segSelector[i] = 16'h0;
      segBase[i]     = 32'h0;
    end
  end

  // ==========================================================================
  // request handshake
  task automatic issue(input agu_pkg::agu_req_type r, output agu_pkg::agu_result_type res,
                       output int lat, output logic gotValid);
    @(posedge clock);
    reqValid <= 1'b1;
    req      <= r;
    lat = -1;
    // answer taken at the rising edge that samples ready; released at that same edge
    do begin
      @(posedge clock);
      lat++;
    end while (reqReady !== 1'b1 && lat < 16);
    gotValid = resultValid;
    res      = result;
    reqValid <= 1'b0;
    // released fields inverted so a stale request can never pass for a live one
    req      <= ~r;
  endtask : issue
endmodule : agu_core_model
`default_nettype wire

// *** tb/address_generation_unit_test.sv ***
// Purpose: self-checking bench for the address generation unit
// Assumes: core model issues requests one at a time
// Notes:   lanes that spill past byte 3 belong to the bus side and are not judged
`timescale 1ns/1ps
`default_nettype none
`define AGU_CHECK(what, exp, got) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
      errCount++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end
module address_generation_unit_test;
  logic                    clock;
  logic                    reset_n;
  logic                    reqValid;
  agu_pkg::agu_req_type    req;
  logic [31:0]             gprFile [agu_pkg::GPR_COUNT];
  logic [15:0]             segSelector [6];
  logic [31:0]             segBase [6];
  logic                    protectEnable;
  logic                    pagingEnable;
  logic                    defaultSize32;
  logic                    reqReady;
  logic                    resultValid;
  agu_pkg::agu_result_type result;
  agu_pkg::agu_result_type lastRes;
  int                      errCount;
  int                      testsRun;

  // ==========================================================================
  // instances
  address_generation_unit u_dut (.clock(clock), .reset_n(reset_n), .reqValid(reqValid), .req(req),
    .gprFile(gprFile), .segSelector(segSelector), .segBase(segBase), .protectEnable(protectEnable),
    .pagingEnable(pagingEnable), .defaultSize32(defaultSize32), .reqReady(reqReady),
    .resultValid(resultValid), .result(result));
  agu_core_model u_core (.clock(clock), .reqValid(reqValid), .req(req), .gprFile(gprFile),
    .segSelector(segSelector), .segBase(segBase), .reqReady(reqReady), .resultValid(resultValid),
    .result(result));

  // ==========================================================================
  // helpers
  function automatic agu_pkg::agu_req_type mk(input agu_pkg::agu_mode_type m, input logic [2:0] b,
                                              input logic [2:0] x, input logic [1:0] s, input logic [31:0] d);
    agu_pkg::agu_req_type r;
    r              = '0;
    r.mode         = m;
    r.refKind      = agu_pkg::AGU_REF_DATA;
    r.baseSel      = b;
    r.indexSel     = x;
    r.scaleLog2    = s;
    r.displacement = d;
    r.dispSize     = (d == 32'h0) ? agu_pkg::AGU_DISP_NONE : agu_pkg::AGU_DISP_32;
    r.opSize       = agu_pkg::AGU_SIZE_DWORD;
    return r;
  endfunction : mk

  task automatic run(input agu_pkg::agu_req_type r, input logic [31:0] ea, input logic [31:0] lin, input int lat);
    int   seen;
    logic v;
    u_core.issue(r, lastRes, seen, v);
    `AGU_CHECK("latency", lat, seen)
    `AGU_CHECK("result valid", 1'b1, v)
    `AGU_CHECK("effective address", ea, lastRes.effectiveAddress)
    `AGU_CHECK("linear address", lin, lastRes.linearAddress)
  endtask : run

  task automatic seg(input agu_pkg::agu_req_type r, input int e, input logic [31:0] ea);
    run(r, ea, (32'(e + 1) << 24) + ea, 1);
    `AGU_CHECK("selector", 16'h0010 + 16'(e), lastRes.selector)
  endtask : seg

  task automatic finishTest();
    if (errCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finishTest

  // ==========================================================================
  // scenarios
  task automatic t_modes();
    agu_pkg::agu_req_type r;
    u_core.gprFile[3] <= 32'h0000_0100;
    u_core.gprFile[4] <= 32'h0000_0777;
    u_core.gprFile[6] <= 32'h0000_0040;
    u_core.segBase[3] <= 32'h0010_0000;
    run(mk(agu_pkg::AGU_MODE_DIRECT, 3'h0, 3'h0, 2'h0, 32'h5678), 32'h5678, 32'h0010_5678, 1);
    run(mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'h3, 3'h0, 2'h0, 32'h0), 32'h100, 32'h0010_0100, 1);
    run(mk(agu_pkg::AGU_MODE_BASED, 3'h3, 3'h0, 2'h0, 32'h8), 32'h108, 32'h0010_0108, 1);
    for (int s = 0; s < 4; s++) begin
      run(mk(agu_pkg::AGU_MODE_SCALED_INDEX, 3'h0, 3'h6, 2'(s), 32'h8), (32'h40 << s) + 32'h8,
          (32'h40 << s) + 32'h0010_0008, 1);
    end
    run(mk(agu_pkg::AGU_MODE_SCALED_INDEX, 3'h0, 3'h4, 2'h0, 32'h30), 32'h30, 32'h0010_0030, 1);
    run(mk(agu_pkg::AGU_MODE_BASED_SCALED, 3'h3, 3'h6, 2'h2, 32'h0), 32'h200, 32'h0010_0200, 2);
    r          = mk(agu_pkg::AGU_MODE_BASED_SCALED_DISP, 3'h3, 3'h6, 2'h3, 32'hffff_fff8);
    r.dispSize = agu_pkg::AGU_DISP_8;
    run(r, 32'h2f8, 32'h0010_02f8, 2);
  endtask : t_modes

  task automatic t_regimm();
    agu_pkg::agu_result_type res;
    int                      lat;
    logic                    v;
    for (int k = 0; k < 2; k++) begin
      u_core.issue(mk(agu_pkg::agu_mode_type'(k), 3'h0, 3'h0, 2'h0, 32'h0), res, lat, v);
      `AGU_CHECK("ready latency", 1, lat)
      `AGU_CHECK("no memory result", 1'b0, v)
    end
  endtask : t_regimm

  task automatic t_wrap();
    u_core.gprFile[3] <= 32'hffff_fff0;
    u_core.segBase[3] <= 32'hffff_ff00;
    run(mk(agu_pkg::AGU_MODE_BASED, 3'h3, 3'h0, 2'h0, 32'h20), 32'h10, 32'hffff_ff10, 1);
    `AGU_CHECK("page request", 1'b0, lastRes.pageRequest)
    `AGU_CHECK("physical address", 24'hffff10, lastRes.physicalAddress)
    pagingEnable <= 1'b1;
    run(mk(agu_pkg::AGU_MODE_BASED, 3'h3, 3'h0, 2'h0, 32'h20), 32'h10, 32'hffff_ff10, 1);
    `AGU_CHECK("page request", 1'b1, lastRes.pageRequest)
    `AGU_CHECK("page number", 20'hfffff, lastRes.pageNumber)
    `AGU_CHECK("page offset", 12'hf10, lastRes.pageOffset)
    pagingEnable <= 1'b0;
  endtask : t_wrap

  task automatic t_segments();
    agu_pkg::agu_req_type r;
    for (int i = 0; i < 6; i++) begin
      u_core.segSelector[i] <= 16'h0010 + 16'(i);
      u_core.segBase[i]     <= 32'(i + 1) << 24;
    end
    u_core.gprFile[3] <= 32'h100;
    u_core.gprFile[4] <= 32'h200;
    u_core.gprFile[5] <= 32'h300;
    seg(mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'h3, 3'h0, 2'h0, 32'h0), 3, 32'h100);
    seg(mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'h5, 3'h0, 2'h0, 32'h0), 2, 32'h300);
    seg(mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'h4, 3'h0, 2'h0, 32'h0), 2, 32'h200);
    for (int e = 0; e < 6; e++) begin
      r               = mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'h3, 3'h0, 2'h0, 32'h0);
      r.overrideValid = 1'b1;
      r.overrideSeg   = agu_pkg::agu_seg_type'(e);
      seg(r, e, 32'h100);
    end
    r.refKind = agu_pkg::AGU_REF_STRING;
    seg(r, 0, 32'h100);
    r.baseSel = 3'h4;
    r.refKind = agu_pkg::AGU_REF_STACK;
    seg(r, 2, 32'h200);
    r              = mk(agu_pkg::AGU_MODE_DIRECT, 3'h0, 3'h0, 2'h0, 32'h0);
    r.refKind      = agu_pkg::AGU_REF_CODE;
    r.instrPointer = 32'h2000;
    r.overrideValid = 1'b1;
    r.overrideSeg  = agu_pkg::AGU_SEG_DATA;
    seg(r, 1, 32'h2000);
  endtask : t_segments

  task automatic t_sizes();
    agu_pkg::agu_req_type r;
    protectEnable          <= 1'b0;
    pagingEnable           <= 1'b1;
    u_core.segSelector[3]  <= 16'h1234;
    u_core.segBase[3]      <= 32'h0040_0000;
    r          = mk(agu_pkg::AGU_MODE_DIRECT, 3'h0, 3'h0, 2'h0, 32'h10);
    r.dispSize = agu_pkg::AGU_DISP_16;
    run(r, 32'h10, 32'h0001_2350, 1);
    `AGU_CHECK("page request", 1'b0, lastRes.pageRequest)
    `AGU_CHECK("address size", 1'b0, lastRes.addr32)
    `AGU_CHECK("physical address", 24'h012350, lastRes.physicalAddress)
    u_core.segSelector[3] <= 16'hffff;
    r.displacement = 32'h20;
    run(r, 32'h20, 32'h0000_0010, 1);
    protectEnable <= 1'b1;
    pagingEnable  <= 1'b0;
    defaultSize32 <= 1'b0;
    r.displacement = 32'hffff_8000;
    run(r, 32'h8000, 32'h0040_8000, 1);
    `AGU_CHECK("address size", 1'b0, lastRes.addr32)
    r.addrSizeToggle = 1'b1;
    r.dispSize       = agu_pkg::AGU_DISP_32;
    r.displacement   = 32'h0001_8000;
    run(r, 32'h0001_8000, 32'h0041_8000, 1);
    `AGU_CHECK("address size", 1'b1, lastRes.addr32)
    defaultSize32 <= 1'b1;
  endtask : t_sizes

  task automatic t_lanes();
    agu_pkg::agu_req_type r;
    logic [31:0]          v;
    int                   n;
    int                   low;
    logic [31:0]          rot [4] = '{32'h4433_2211, 32'h3322_1144, 32'h2211_4433, 32'h1144_3322};
    // flat space: every base zero, so linear equals the register value
    for (int i = 0; i < 6; i++) begin
      u_core.segBase[i] <= 32'h0;
    end
    for (int i = 0; i < 8; i++) begin
      u_core.gprFile[i] <= (32'(i) << 12) | 32'(i);
    end
    for (int i = 0; i < 8; i++) begin
      r           = mk(agu_pkg::AGU_MODE_REG_INDIRECT, 3'(i), 3'h0, 2'h0, 32'h0);
      r.opSize    = agu_pkg::agu_size_type'(i % 3);
      r.storeData = 32'h4433_2211;
      v           = (32'(i) << 12) | 32'(i);
      run(r, v, v, 1);
      n   = (i % 3 == 0) ? 1 : (i % 3 == 1) ? 2 : 4;
      low = int'(v[1:0]);
      if (low + n <= 4) begin
        `AGU_CHECK("byte enable", 4'(((1 << n) - 1) << low), lastRes.byteEnable)
        `AGU_CHECK("lane data", rot[low], lastRes.laneData)
      end
    end
  endtask : t_lanes

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever begin
      #50 clock = ~clock;
    end
  end

  initial begin
    errCount      = 0;
    testsRun      = 0;
    reset_n       = 1'b0;
    protectEnable = 1'b1;
    pagingEnable  = 1'b0;
    defaultSize32 = 1'b1;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_modes();
    t_regimm();
    t_wrap();
    t_segments();
    t_sizes();
    t_lanes();
    finishTest();
  end

  initial begin
    // 38 requests of at most four cycles each; generous margin
    repeat (3000) @(posedge clock);
    errCount++;
    finishTest();
  end
endmodule : address_generation_unit_test
`default_nettype wire
